// file: shared/loop_code_pkg.sv
// package for the in-band loop code generator and detectors
// assumes one 40 MHz register clock; bit strobes come from the framer
package loop_code_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_LEN_CTRL   = 6'h12;
    localparam logic [5:0] IDX_TX_PAT     = 6'h13;
    localparam logic [5:0] IDX_UP_PAT     = 6'h14;
    localparam logic [5:0] IDX_DN_PAT     = 6'h15;
    localparam logic [5:0] IDX_CTRL_3     = 6'h16;
    localparam logic [5:0] IDX_MODE       = 6'h17;
    localparam logic [5:0] IDX_STATUS_ONE = 6'h18;
    localparam logic [5:0] IDX_IRQ_STAT   = 6'h19;
    localparam logic [5:0] IDX_IRQ_CLR    = 6'h1a;
    localparam logic [5:0] IDX_IRQ_EN     = 6'h1b;

    // field positions
    localparam int TX_LEN_MSB    = 7;
    localparam int TX_LEN_LSB    = 6;
    localparam int UP_LEN_MSB    = 5;
    localparam int UP_LEN_LSB    = 3;
    localparam int DN_LEN_MSB    = 2;
    localparam int DN_LEN_LSB    = 0;
    localparam int TX_LOOP_EN    = 1;
    localparam int MODE_SKIP_F   = 0;
    localparam int MODE_RX_FRM   = 1;
    localparam int UP_FLAG_BIT   = 7;
    localparam int DN_FLAG_BIT   = 6;
    localparam int IRQ_UP_BIT    = 0;
    localparam int IRQ_DN_BIT    = 1;

    // reset values
    localparam logic [7:0] RST_LEN_CTRL = 8'h00;
    localparam logic [7:0] RST_TX_PAT   = 8'h00;
    localparam logic [7:0] RST_UP_PAT   = 8'h00;
    localparam logic [7:0] RST_DN_PAT   = 8'h00;
    localparam logic [7:0] RST_CTRL_3   = 8'h00;
    localparam logic [7:0] RST_MODE     = 8'h00;
    localparam logic [1:0] RST_IRQ      = 2'h0;

    // timing
    localparam int CLK_HZ       = 40_000_000;
    localparam int INTEG_MS     = 48;
    localparam int INTEG_CYCLES = INTEG_MS * (CLK_HZ / 1000);
    localparam int CNT_W        = 21;
    localparam int FRAME_BITS   = 193;

    typedef struct packed {
        logic [7:0] pattern;
        logic [2:0] len_sel;
    } detect_cfg_t;

    // receive length field is plain binary plus one
    function automatic logic [3:0] rx_len(input logic [2:0] sel);
        rx_len = {1'b0, sel} + 4'h1;
    endfunction : rx_len

    function automatic logic [3:0] tx_len(input logic [1:0] sel);
        case (sel)
            2'h0:    tx_len = 4'h5;
            2'h1:    tx_len = 4'h6;
            2'h2:    tx_len = 4'h7;
            default: tx_len = 4'h8;
        endcase
    endfunction : tx_len

    // h[0] is the newest bit; true if the last n bits are any phase of the code
    function automatic logic code_match(input logic [7:0] h, input logic [7:0] c,
                                        input logic [3:0] n);
        logic hit;
        logic ok;
        int   idx;
        hit = 1'b0;
        for (int p = 0; p < 8; p++) begin
            ok = (p < int'(n));
            for (int i = 0; i < 8; i++) begin
                idx = p + int'(n) - i;
                if (idx >= int'(n)) begin
                    idx = idx - int'(n);
                end
                if (i < int'(n) && h[i] != c[7 - (idx & 7)]) begin
                    ok = 1'b0;
                end
            end
            hit = hit | ok;
        end
        code_match = hit;
    endfunction : code_match
endpackage : loop_code_pkg

// file: design/loop_code_detector.sv
// one receive loop code detector with error-tolerant integration
// assumes win_end pulses once per integration window from the parent
`timescale 1ns/100ps
`default_nettype none
module loop_code_detector (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       ce,
    input  wire logic                       bit_en,
    input  wire logic                       rx_bit,
    input  wire loop_code_pkg::detect_cfg_t cfg,
    input  wire logic                       win_end,
    output logic                            detected_ff
);
    localparam int W = loop_code_pkg::CNT_W;

    logic [7:0]   hist_ff;
    logic [3:0]   fill_ff;
    logic [W-1:0] bits_ff;
    logic [W-1:0] miss_ff;
    logic [7:0]   nxt_hist;
    logic [3:0]   len;
    logic         hit;
    logic         pass;

    assign nxt_hist = {hist_ff[6:0], rx_bit};
    assign len      = loop_code_pkg::rx_len(cfg.len_sel);
    assign hit      = loop_code_pkg::code_match(nxt_hist, cfg.pattern, len);
    // one bit error spoils up to eight windows: 1 in 100 errors gives about 8% misses,
    // so up to 1/8 misses still passes while a foreign code misses far more often
    assign pass     = (bits_ff != '0) && (miss_ff <= (bits_ff >> 3));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist_ff <= 8'h00;
            fill_ff <= 4'h0;
        end else if (ce && bit_en) begin
            hist_ff <= nxt_hist;
            if (fill_ff != 4'h8) begin
                fill_ff <= fill_ff + 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bits_ff <= '0;
            miss_ff <= '0;
        end else if (ce) begin
            if (win_end) begin
                bits_ff <= '0;
                miss_ff <= '0;
            end else if (bit_en && fill_ff >= len) begin
                bits_ff <= bits_ff + W'(1);
                if (!hit) begin
                    miss_ff <= miss_ff + W'(1);
                end
            end
        end
    end

    // flag follows each window's verdict, so it also drops when the code stops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            detected_ff <= 1'b0;
        end else if (ce && win_end) begin
            detected_ff <= pass;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_det_drop;
        ce && win_end && !pass |=> !detected_ff;
    endproperty
    a_det_drop: assert property (p_det_drop) else $error("flag kept after failed window");

    property p_det_hold;
        !(ce && win_end) |=> $stable(detected_ff);
    endproperty
    a_det_hold: assert property (p_det_hold) else $error("flag moved inside window");
endmodule : loop_code_detector
`default_nettype wire

// file: design/loop_code_unit.sv
// in-band loop code generator, two detectors and their APB registers
// assumes bit strobes synchronous to pclk, one strobe per line bit
// Operation
// - repeating patterns of five to eight bits are generated, one to eight bits detected
// - pattern is sent exactly while the transmit loop enable bit is set
// - framing bit replaces the pattern once per 193 bits unless skipped
// - length control: tx length 7:6, up length 5:3, down length 2:0
// - receive length fields are binary: 000 is one bit, 111 eight bits
// - transmit pattern bit 7 goes first; bits past the length are ignored
// - up and down detectors run independently, each with its own length
// - detection works framed or unframed with error rates up to 1 in 100
// - each detector integrates about 48 ms before setting its flag
// - up flag is status bit 7, down flag is status bit 6
// - receive pattern bit 7 is first; bits past the length are ignored
`timescale 1ns/100ps
`default_nettype none
module loop_code_unit #(
    parameter int unsigned INTEG_CYCLES = loop_code_pkg::INTEG_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        tx_bit_en,
    input  wire logic        tx_payload,
    input  wire logic        tx_fbit_val,
    output logic             tx_data_ff,
    input  wire logic        rx_bit_en,
    input  wire logic        rx_data,
    input  wire logic        rx_fbit,
    output logic             up_code_detected,
    output logic             down_code_detected,
    output logic             irq_ff
);
    localparam int W = loop_code_pkg::CNT_W;

    logic [7:0]   len_ctrl_ff;
    logic [7:0]   tx_pat_ff;
    logic [7:0]   up_pat_ff;
    logic [7:0]   dn_pat_ff;
    logic [7:0]   ctrl_3_ff;
    logic [7:0]   mode_ff;
    logic [1:0]   irq_stat_ff;
    logic [1:0]   irq_en_ff;
    logic [1:0]   flags_d_ff;
    logic [3:0]   phase_ff;
    logic [7:0]   fpos_ff;
    logic [W-1:0] win_cnt_ff;
    logic         win_end;
    logic [5:0]   idx;
    logic         aligned;
    logic         wr_acc;
    logic         setup;
    logic [3:0]   tx_len;
    logic         tx_loop_en;
    logic         pat_bit;
    logic         f_slot;
    logic         det_bit_en;
    logic [1:0]   flags;
    logic [1:0]   rise;
    logic         mapped;
    logic [31:0]  rd_val;
    loop_code_pkg::detect_cfg_t up_cfg;
    loop_code_pkg::detect_cfg_t dn_cfg;

    assign idx     = paddr[7:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign setup   = psel && !penable;
    assign wr_acc  = psel && penable && pready && pwrite && !pslverr;

    // read decode; write-only clear register reads as zero
    always_comb begin
        rd_val = 32'h0000_0000;
        mapped = aligned;
        case (idx)
            loop_code_pkg::IDX_LEN_CTRL:   rd_val[7:0] = len_ctrl_ff;
            loop_code_pkg::IDX_TX_PAT:     rd_val[7:0] = tx_pat_ff;
            loop_code_pkg::IDX_UP_PAT:     rd_val[7:0] = up_pat_ff;
            loop_code_pkg::IDX_DN_PAT:     rd_val[7:0] = dn_pat_ff;
            loop_code_pkg::IDX_CTRL_3:     rd_val[7:0] = ctrl_3_ff;
            loop_code_pkg::IDX_MODE:       rd_val[7:0] = mode_ff;
            loop_code_pkg::IDX_STATUS_ONE: begin
                rd_val[loop_code_pkg::UP_FLAG_BIT] = up_code_detected;
                rd_val[loop_code_pkg::DN_FLAG_BIT] = down_code_detected;
            end
            loop_code_pkg::IDX_IRQ_STAT:   rd_val[1:0] = irq_stat_ff;
            loop_code_pkg::IDX_IRQ_CLR:    rd_val[1:0] = 2'h0;
            loop_code_pkg::IDX_IRQ_EN:     rd_val[1:0] = irq_en_ff;
            default:                       mapped = 1'b0;
        endcase
    end

    // answer is prepared in the setup cycle, so the access phase never waits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            if (setup && !pwrite && mapped) begin
                prdata <= rd_val;
            end else if (setup) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            len_ctrl_ff <= loop_code_pkg::RST_LEN_CTRL;
            tx_pat_ff   <= loop_code_pkg::RST_TX_PAT;
            up_pat_ff   <= loop_code_pkg::RST_UP_PAT;
            dn_pat_ff   <= loop_code_pkg::RST_DN_PAT;
            ctrl_3_ff   <= loop_code_pkg::RST_CTRL_3;
            mode_ff     <= loop_code_pkg::RST_MODE;
            irq_en_ff   <= loop_code_pkg::RST_IRQ;
        end else if (ce && wr_acc) begin
            case (idx)
                loop_code_pkg::IDX_LEN_CTRL: len_ctrl_ff <= pwdata[7:0];
                loop_code_pkg::IDX_TX_PAT:   tx_pat_ff   <= pwdata[7:0];
                loop_code_pkg::IDX_UP_PAT:   up_pat_ff   <= pwdata[7:0];
                loop_code_pkg::IDX_DN_PAT:   dn_pat_ff   <= pwdata[7:0];
                loop_code_pkg::IDX_CTRL_3:   ctrl_3_ff   <= pwdata[7:0];
                loop_code_pkg::IDX_MODE:     mode_ff     <= pwdata[7:0];
                loop_code_pkg::IDX_IRQ_EN:   irq_en_ff   <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    // transmit side
    assign tx_len     = loop_code_pkg::tx_len(
                            len_ctrl_ff[loop_code_pkg::TX_LEN_MSB:loop_code_pkg::TX_LEN_LSB]);
    assign tx_loop_en = ctrl_3_ff[loop_code_pkg::TX_LOOP_EN];
    assign pat_bit    = tx_pat_ff[3'(4'h7 - phase_ff)];
    assign f_slot     = (fpos_ff == 8'h00) && !mode_ff[loop_code_pkg::MODE_SKIP_F];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fpos_ff <= 8'h00;
        end else if (ce && tx_bit_en) begin
            fpos_ff <= (fpos_ff == 8'(loop_code_pkg::FRAME_BITS - 1)) ? 8'h00
                                                                        : fpos_ff + 8'h01;
        end
    end

    // the pattern keeps running under the framing bit; it restarts at bit 7 when enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_ff <= 4'h0;
        end else if (ce && (!tx_loop_en || phase_ff >= tx_len)) begin
            phase_ff <= 4'h0;
        end else if (ce && tx_bit_en) begin
            phase_ff <= (phase_ff == tx_len - 4'h1) ? 4'h0 : phase_ff + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_data_ff <= 1'b0;
        end else if (ce && tx_bit_en) begin
            if (f_slot) begin
                tx_data_ff <= tx_fbit_val;
            end else if (tx_loop_en) begin
                tx_data_ff <= pat_bit;
            end else begin
                tx_data_ff <= tx_payload;
            end
        end
    end

    // receive side: shared integration window for both detectors
    assign win_end = (win_cnt_ff == W'(INTEG_CYCLES - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_cnt_ff <= '0;
        end else if (ce) begin
            win_cnt_ff <= win_end ? '0 : win_cnt_ff + W'(1);
        end
    end

    assign det_bit_en = rx_bit_en && !(mode_ff[loop_code_pkg::MODE_RX_FRM] && rx_fbit);
    assign up_cfg = '{pattern: up_pat_ff,
                      len_sel: len_ctrl_ff[loop_code_pkg::UP_LEN_MSB:loop_code_pkg::UP_LEN_LSB]};
    assign dn_cfg = '{pattern: dn_pat_ff,
                      len_sel: len_ctrl_ff[loop_code_pkg::DN_LEN_MSB:loop_code_pkg::DN_LEN_LSB]};

    // two independent detectors
    loop_code_detector u_up (
        .pclk        (pclk),
        .presetn     (presetn),
        .ce          (ce),
        .bit_en      (det_bit_en),
        .rx_bit      (rx_data),
        .cfg         (up_cfg),
        .win_end     (win_end),
        .detected_ff (up_code_detected)
    );

    loop_code_detector u_dn (
        .pclk        (pclk),
        .presetn     (presetn),
        .ce          (ce),
        .bit_en      (det_bit_en),
        .rx_bit      (rx_data),
        .cfg         (dn_cfg),
        .win_end     (win_end),
        .detected_ff (down_code_detected)
    );

    // interrupts on each new detection; a new event wins over a clear
    assign flags = {down_code_detected, up_code_detected};
    assign rise  = flags & ~flags_d_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_d_ff  <= 2'h0;
            irq_stat_ff <= loop_code_pkg::RST_IRQ;
            irq_ff      <= 1'b0;
        end else if (ce) begin
            flags_d_ff <= flags;
            if (wr_acc && idx == loop_code_pkg::IDX_IRQ_CLR) begin
                irq_stat_ff <= (irq_stat_ff & ~pwdata[1:0]) | rise;
            end else begin
                irq_stat_ff <= irq_stat_ff | rise;
            end
            irq_ff <= |(irq_stat_ff & irq_en_ff);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_tx_bit;
        ce && tx_bit_en;
    endsequence

    sequence s_rd_setup(logic [5:0] i);
        ce && setup && !pwrite && aligned && idx == i;
    endsequence

    property p_tx_fbit;
        s_tx_bit ##0 f_slot |=> tx_data_ff == $past(tx_fbit_val);
    endproperty
    a_tx_fbit: assert property (p_tx_fbit) else $error("framing bit not inserted");

    property p_tx_pat;
        s_tx_bit ##0 (!f_slot && tx_loop_en) |=> tx_data_ff == $past(pat_bit);
    endproperty
    a_tx_pat: assert property (p_tx_pat) else $error("wrong loop pattern bit");

    property p_tx_off;
        s_tx_bit ##0 (!f_slot && !tx_loop_en) |=> tx_data_ff == $past(tx_payload);
    endproperty
    a_tx_off: assert property (p_tx_off) else $error("pattern sent while disabled");

    property p_phase;
        tx_loop_en && phase_ff < tx_len && ce && tx_bit_en |=> phase_ff < $past(tx_len);
    endproperty
    a_phase: assert property (p_phase) else $error("pattern phase past length");

    property p_fpos;
        fpos_ff < 8'(loop_code_pkg::FRAME_BITS);
    endproperty
    a_fpos: assert property (p_fpos) else $error("frame position out of range");

    property p_status;
        s_rd_setup(loop_code_pkg::IDX_STATUS_ONE) |=>
            prdata[loop_code_pkg::UP_FLAG_BIT] == $past(up_code_detected) &&
            prdata[loop_code_pkg::DN_FLAG_BIT] == $past(down_code_detected) && pready;
    endproperty
    a_status: assert property (p_status) else $error("status flags misreported");

    property p_len_wr;
        ce && wr_acc && idx == loop_code_pkg::IDX_LEN_CTRL |=> len_ctrl_ff == $past(pwdata[7:0]);
    endproperty
    a_len_wr: assert property (p_len_wr) else $error("length control not written");

    property p_irq;
        ce && rise[0] |=> irq_stat_ff[loop_code_pkg::IRQ_UP_BIT] ##1
            (!ce || irq_ff == irq_en_ff[loop_code_pkg::IRQ_UP_BIT] || irq_stat_ff[1]);
    endproperty
    a_irq: assert property (p_irq) else $error("detection event lost");
endmodule : loop_code_unit
`default_nettype wire

// file: test/line_far_end.sv
// remote line equipment model: repeats a loop code towards the receive side
// assumes it shares pclk with the unit and strobes one bit every 4 cycles
`timescale 1ns/100ps
`default_nettype none
module line_far_end (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       run_code,
    input  wire logic       framed_line,
    input  wire logic [7:0] line_code,
    input  wire logic [3:0] code_len,
    input  wire logic [7:0] err_every,
    output logic            rx_bit_en,
    output logic            rx_data,
    output logic            rx_fbit
);
    logic [1:0] div_ff;
    logic [2:0] phase_ff;
    logic [7:0] frame_ff;
    logic [7:0] errc_ff;
    logic       hit_err;

    assign hit_err = (err_every != 8'h00) && (errc_ff + 8'h01 == err_every);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff    <= 2'h0;
            phase_ff  <= 3'h0;
            frame_ff  <= 8'h00;
            errc_ff   <= 8'h00;
            rx_bit_en <= 1'b0;
            rx_data   <= 1'b0;
            rx_fbit   <= 1'b0;
        end else begin
            div_ff    <= div_ff + 2'h1;
            rx_bit_en <= 1'b0;
            rx_fbit   <= 1'b0;
            // between strobes the data line keeps changing, never a stale bit
            rx_data   <= ~rx_data;
            if (run_code && div_ff == 2'h3) begin
                rx_bit_en <= 1'b1;
                frame_ff  <= (frame_ff == 8'hc0) ? 8'h00 : frame_ff + 8'h01;
                if (framed_line && frame_ff == 8'h00) begin
                    // framing slot carries a wrong bit; pattern phase is held
                    rx_fbit <= 1'b1;
                    rx_data <= ~line_code[3'h7 - phase_ff];
                end else begin
                    // one flipped bit every err_every code bits
                    errc_ff  <= hit_err ? 8'h00 : errc_ff + 8'h01;
                    rx_data  <= line_code[3'h7 - phase_ff] ^ hit_err;
                    phase_ff <= ({1'b0, phase_ff} + 4'h1 == code_len) ? 3'h0 : phase_ff + 3'h1;
                end
            end
        end
    end
endmodule : line_far_end
`default_nettype wire

// file: test/inband_loop_code_gen_detect_bench.sv
// self-checking bench: APB register tasks, transmit bit checks, loop code detection
// assumes one 40 MHz clock and a shortened integration window
`timescale 1ns/100ps
`default_nettype none
module inband_loop_code_gen_detect_bench;
    localparam int INTEG = 1200;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, tx_data_ff, up_flag, dn_flag, irq_ff;
    logic        tx_bit_en = 1'b0;
    logic        tx_payload = 1'b0;
    logic        fbit_val = 1'b0;
    logic        rx_bit_en, rx_data, rx_fbit;
    logic        run_code = 1'b0;
    logic        framed_line = 1'b0;
    logic [7:0]  line_code = 8'h80;
    logic [3:0]  code_len = 4'h5;
    logic [7:0]  err_every = 8'h64;
    logic        skip = 1'b0;
    int          errors = 0;
    int          n_compared = 0;
    int          tx_cnt = 0;
    int          cyc = 0;
    logic [7:0]  pats [1:3] = '{8'hb7, 8'h9b, 8'hd2};

    always #12.5 pclk = ~pclk;

    loop_code_unit #(.INTEG_CYCLES(INTEG)) loop_code_unit_inst (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_bit_en(tx_bit_en),
        .tx_payload(tx_payload), .tx_fbit_val(fbit_val), .tx_data_ff(tx_data_ff),
        .rx_bit_en(rx_bit_en), .rx_data(rx_data), .rx_fbit(rx_fbit),
        .up_code_detected(up_flag), .down_code_detected(dn_flag), .irq_ff(irq_ff));

    line_far_end line_far_end_inst (
        .pclk(pclk), .presetn(presetn), .run_code(run_code), .framed_line(framed_line),
        .line_code(line_code), .code_len(code_len), .err_every(err_every),
        .rx_bit_en(rx_bit_en), .rx_data(rx_data), .rx_fbit(rx_fbit));

    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            errors++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'h0};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) errors++;
    endtask : apb

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, idx, {24'h0, d}, r, e);
    endtask : wr

    task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp, input logic exp_err);
        logic [31:0] r;
        logic        e;
        apb(1'b0, idx, 32'h0, r, e);
        chk({24'h0, exp}, r);
        chk({31'h0, exp_err}, {31'h0, e});
    endtask : rd_chk

    // restarts the generator so the pattern phase begins at bit 7
    task automatic tx_cfg(input logic [1:0] lsel, input logic [7:0] pat, input logic skp);
        wr(loop_code_pkg::IDX_CTRL_3, 8'h00);
        wr(loop_code_pkg::IDX_LEN_CTRL, {lsel, 6'h00});
        wr(loop_code_pkg::IDX_TX_PAT, pat);
        rd_chk(loop_code_pkg::IDX_TX_PAT, pat, 1'b0);
        wr(loop_code_pkg::IDX_MODE, {7'h0, skp});
        skip = skp;
        wr(loop_code_pkg::IDX_CTRL_3, 8'h02);
    endtask : tx_cfg

    task automatic tx_run(input int n, input logic en, input logic [7:0] pat, input int len);
        logic exp;
        for (int k = 0; k < n; k++) begin
            @(posedge pclk);
            tx_bit_en  <= 1'b1;
            tx_payload <= k[1];
            fbit_val   <= tx_cnt[0];
            @(posedge pclk);
            tx_bit_en  <= 1'b0;
            #1;
            if (!skip && tx_cnt % 193 == 0) exp = tx_cnt[0];
            else if (en) exp = pat[7 - (k % len)];
            else exp = k[1];
            chk({31'h0, exp}, {31'h0, tx_data_ff});
            tx_cnt++;
        end
    endtask : tx_run

    task automatic wait_flags(input logic eu, input logic ed);
        int n;
        n = 0;
        // a code present from a window start must be flagged within three windows
        while ({up_flag, dn_flag} !== {eu, ed} && n < 3 * INTEG + 50) begin
            @(posedge pclk);
            n++;
        end
        chk({30'h0, eu, ed}, {30'h0, up_flag, dn_flag});
        rd_chk(loop_code_pkg::IDX_STATUS_ONE, {eu, ed, 6'h00}, 1'b0);
    endtask : wait_flags

    initial begin
        logic [5:0] idxs [9] = '{loop_code_pkg::IDX_LEN_CTRL, loop_code_pkg::IDX_TX_PAT,
            loop_code_pkg::IDX_UP_PAT, loop_code_pkg::IDX_DN_PAT, loop_code_pkg::IDX_CTRL_3,
            loop_code_pkg::IDX_MODE, loop_code_pkg::IDX_STATUS_ONE,
            loop_code_pkg::IDX_IRQ_STAT, loop_code_pkg::IDX_IRQ_EN};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        foreach (idxs[i]) rd_chk(idxs[i], 8'h00, 1'b0);
        rd_chk(6'h00, 8'h00, 1'b1);
        rd_chk(loop_code_pkg::IDX_IRQ_CLR, 8'h00, 1'b0);
        wr(loop_code_pkg::IDX_STATUS_ONE, 8'hff);
        rd_chk(loop_code_pkg::IDX_STATUS_ONE, 8'h00, 1'b0);
        // low bits past the length are set on purpose and must be ignored
        tx_cfg(2'h0, 8'h87, 1'b0);
        tx_run(200, 1'b1, 8'h87, 5);
        for (int s = 1; s <= 3; s++) begin
            tx_cfg(s[1:0], pats[s], 1'b0);
            tx_run(40, 1'b1, pats[s], s + 5);
        end
        tx_cfg(2'h3, 8'hd2, 1'b1);
        tx_run(80, 1'b1, 8'hd2, 8);
        wr(loop_code_pkg::IDX_CTRL_3, 8'h00);
        tx_run(10, 1'b0, 8'h00, 8);
        wr(loop_code_pkg::IDX_MODE, 8'h00);
        skip = 1'b0;
        wr(loop_code_pkg::IDX_LEN_CTRL, 8'h27);
        rd_chk(loop_code_pkg::IDX_LEN_CTRL, 8'h27, 1'b0);
        wr(loop_code_pkg::IDX_UP_PAT, 8'h87);
        wr(loop_code_pkg::IDX_DN_PAT, 8'h3c);
        wr(loop_code_pkg::IDX_IRQ_EN, 8'h01);
        run_code <= 1'b1;
        wait_flags(1'b1, 1'b0);
        repeat (3) @(posedge pclk);
        rd_chk(loop_code_pkg::IDX_IRQ_STAT, 8'h01, 1'b0);
        chk(32'h1, {31'h0, irq_ff});
        wr(loop_code_pkg::IDX_IRQ_CLR, 8'h01);
        repeat (3) @(posedge pclk);
        chk(32'h0, {31'h0, irq_ff});
        rd_chk(loop_code_pkg::IDX_STATUS_ONE, 8'h80, 1'b0);
        wr(loop_code_pkg::IDX_MODE, 8'h02);
        framed_line <= 1'b1;
        line_code   <= 8'h3c;
        code_len    <= 4'h8;
        wait_flags(1'b0, 1'b1);
        repeat (3) @(posedge pclk);
        rd_chk(loop_code_pkg::IDX_IRQ_STAT, 8'h02, 1'b0);
        chk(32'h0, {31'h0, irq_ff});
        wr(loop_code_pkg::IDX_IRQ_EN, 8'h03);
        repeat (3) @(posedge pclk);
        chk(32'h1, {31'h0, irq_ff});
        wr(loop_code_pkg::IDX_IRQ_CLR, 8'h03);
        repeat (3) @(posedge pclk);
        chk(32'h0, {31'h0, irq_ff});
        run_code <= 1'b0;
        wait_flags(1'b0, 1'b0);
        tally_and_finish();
    end
endmodule : inband_loop_code_gen_detect_bench
`default_nettype wire
